// ===== voltage_dac_control.sv
// register block and bus slave for the four voltage converter channels
`timescale 1ns/1ps
module voltage_dac_control import dac_pkg::*; (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	// write address channel
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// write data channel
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response channel
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address channel
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// read data channel
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// update source
	input wire logic update_timer_evt,
	// converter side, one slice per channel
	output logic [NCH*CODE_W-1:0] analog_code,
	output logic [NCH-1:0] analog_output_pin_oe,
	output logic [NCH-1:0] buffer_low_power,
	output logic [NCH-1:0] buffer_skip,
	output logic [NCH*RANGE_W-1:0] reference_range
);
	// control registers, bits 8:0 only
	logic [CTRL_W-1:0] ctrl_reg [NCH];
	// code registers, bits 27:12 only
	logic [CODE_W+FRAC_W-1:0] data_reg [NCH];

	// captured write address and data
	logic aw_held_reg;
	logic [31:0] aw_addr_reg;
	logic w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;

	// helper flags for checks on read data
	logic rd_ctrl_reg;
	logic rd_data_reg;

	// decoded write and read targets
	logic [3:0] wr_dec;
	logic [3:0] rd_dec;
	logic wr_fire;

	// protection bits carry no meaning here
	logic unused_prot;
	assign unused_prot = ^{awprot, arprot};

	assign wr_dec = reg_decode(aw_addr_reg);
	assign rd_dec = reg_decode(araddr);

	// a write is done once both halves are held and no response waits
	assign wr_fire = clk_en && aw_held_reg && w_held_reg && !bvalid;

	// merge a byte-enabled write into a register image
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction

	// word image of a control register, reserved bits zero
	function automatic logic [31:0] ctrl_word(input logic [CTRL_W-1:0] c);
		return {23'h0, c};
	endfunction

	// word image of a code register, reserved bits zero
	function automatic logic [31:0] data_word(input logic [CODE_W+FRAC_W-1:0] d);
		return {4'h0, d, 12'h000};
	endfunction

	// stored field of a code register image, bits 27:12
	function automatic logic [CODE_W+FRAC_W-1:0] data_field(input logic [31:0] w);
		return w[CODE_LSB+CODE_W-1:FRAC_LSB];
	endfunction

	// write address capture; ready drops while an address is held
	// holding the address until the answer keeps a second write waiting
	always_ff @(posedge core_clk) begin
		if (reset) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			awready <= 1'b1;
		end else if (clk_en) begin
			if (awvalid && awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= awaddr;
				awready <= 1'b0;
			end else if (bvalid && bready) begin
				// release for the next write once answered
				aw_held_reg <= 1'b0;
				awready <= 1'b1;
			end
		end
	end

	// write data capture, independent of the address
	always_ff @(posedge core_clk) begin
		if (reset) begin
			w_held_reg <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			wready <= 1'b1;
		end else if (clk_en) begin
			if (wvalid && wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
				wready <= 1'b0;
			end else if (bvalid && bready) begin
				w_held_reg <= 1'b0;
				wready <= 1'b1;
			end
		end
	end

	// write response; unmapped addresses answer with an error
	always_ff @(posedge core_clk) begin
		if (reset) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (clk_en) begin
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= wr_dec[3] ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// control registers; only bytes 0 and 1 hold bits
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < NCH; i++) begin
				ctrl_reg[i] <= CTRL_RESET;
			end
		end else if (wr_fire && wr_dec[3] && !wr_dec[2]) begin
			// bits above 8 are dropped so they keep reading zero
			ctrl_reg[wr_dec[1:0]] <= CTRL_W'(merge_bytes(ctrl_word(ctrl_reg[wr_dec[1:0]]), w_data_reg, w_strb_reg));
		end
	end

	// code registers; held at zero while the clear bit is low
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < NCH; i++) begin
				data_reg[i] <= DATA_RESET;
			end
		end else if (clk_en) begin
			for (int i = 0; i < NCH; i++) begin
				if (!ctrl_reg[i][CLR_BIT]) begin
					// clear wins over a write in the same cycle
					data_reg[i] <= DATA_RESET;
				end else if (wr_fire && wr_dec[3] && wr_dec[2] && wr_dec[1:0] == 2'(i)) begin
					data_reg[i] <= data_field(merge_bytes(data_word(data_reg[i]), w_data_reg, w_strb_reg));
				end
			end
		end
	end

	// read channel; answer one cycle after the address is taken
	// data is captured at the address handshake, so a later write cannot alter it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (clk_en) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				if (!rd_dec[3]) begin
					// unmapped: zero data and an error
					rdata <= '0;
					rresp <= RESP_SLVERR;
				end else if (rd_dec[2]) begin
					rdata <= data_word(data_reg[rd_dec[1:0]]);
					rresp <= RESP_OKAY;
				end else begin
					rdata <= ctrl_word(ctrl_reg[rd_dec[1:0]]);
					rresp <= RESP_OKAY;
				end
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// remember what kind of register the pending read came from
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rd_ctrl_reg <= 1'b0;
			rd_data_reg <= 1'b0;
		end else if (clk_en && arvalid && arready) begin
			rd_ctrl_reg <= rd_dec[3] && !rd_dec[2];
			rd_data_reg <= rd_dec[3] && rd_dec[2];
		end
	end

	// one converter channel per register pair, all alike
	// the timer event is shared; each channel picks its own update source
	for (genvar g = 0; g < NCH; g++) begin : g_chan
		dac_channel_core u_core (
			.core_clk(core_clk),
			.reset(reset),
			.clk_en(clk_en),
			.ctrl(ctrl_reg[g]),
			.code_in(data_reg[g]),
			.update_timer_evt(update_timer_evt),
			.code_out(analog_code[g*CODE_W +: CODE_W]),
			.pin_oe(analog_output_pin_oe[g]),
			.amp_low_power(buffer_low_power[g]),
			.amp_skip(buffer_skip[g]),
			.range_out(reference_range[g*RANGE_W +: RANGE_W])
		);

		// clear bit low keeps the code register at zero
		chk_clear_forces: assert property (@(posedge core_clk) disable iff (reset)
			clk_en && !ctrl_reg[g][CLR_BIT] |=> data_reg[g] == DATA_RESET)
			else $error("code register not cleared");
	end

	// checks on the bus side and reset values
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// both halves of a write taken in the same cycle
	sequence sq_both_taken;
		clk_en && awvalid && awready && wvalid && wready;
	endsequence

	// the next enabled cycle performs the write
	sequence sq_write_done;
		sq_both_taken ##1 clk_en;
	endsequence

	chk_reset_values: assert property ($fell(reset) |-> ctrl_reg[0] == CTRL_RESET && data_reg[3] == DATA_RESET)
		else $error("wrong register value after reset");
	chk_write_answer: assert property (sq_write_done |=> bvalid)
		else $error("write response missing");
	chk_read_answer: assert property (clk_en && arvalid && arready |=> rvalid && !arready)
		else $error("read answer missing");
	chk_ctrl_rsvd: assert property (rvalid && rd_ctrl_reg |-> rdata[31:9] == 0)
		else $error("reserved control bits not zero");
	chk_data_rsvd: assert property (rvalid && rd_data_reg |-> rdata[31:28] == 0 && rdata[11:0] == 0)
		else $error("reserved code bits not zero");

	// a write to no register is answered with an error
	chk_write_refused: assert property (wr_fire && !wr_dec[3] |=> bvalid && bresp == RESP_SLVERR)
		else $error("unmapped write not refused");

	// a write to a register is answered with okay
	chk_write_okay: assert property (wr_fire && wr_dec[3] |=> bvalid && bresp == RESP_OKAY)
		else $error("mapped write not answered okay");

	// a read of no register returns zero and an error
	chk_read_refused: assert property (clk_en && arvalid && arready && !rd_dec[3]
		|=> rvalid && rresp == RESP_SLVERR && rdata == 0)
		else $error("unmapped read not refused");

	// a full control write lands in the addressed register
	chk_ctrl_store: assert property (wr_fire && wr_dec[3] && !wr_dec[2] && w_strb_reg[1:0] == 2'h3
		|=> ctrl_reg[$past(wr_dec[1:0])] == $past(w_data_reg[CTRL_W-1:0]))
		else $error("control write lost");

	// a full code write lands while the clear bit is high
	chk_code_store: assert property (wr_fire && wr_dec[3] && wr_dec[2] && w_strb_reg == 4'hF
		&& ctrl_reg[wr_dec[1:0]][CLR_BIT]
		|=> data_reg[$past(wr_dec[1:0])] == $past(w_data_reg[CODE_LSB+CODE_W-1:FRAC_LSB]))
		else $error("code write lost");

	// a code write is dropped while the clear bit is low
	chk_code_refused: assert property (wr_fire && wr_dec[3] && wr_dec[2] && !ctrl_reg[wr_dec[1:0]][CLR_BIT]
		|=> data_reg[$past(wr_dec[1:0])] == DATA_RESET)
		else $error("code write taken while cleared");

	// control registers change only through a write
	chk_ctrl_keep: assert property (!wr_fire
		|=> $stable(ctrl_reg[0]) && $stable(ctrl_reg[1]) && $stable(ctrl_reg[2]) && $stable(ctrl_reg[3]))
		else $error("control changed without a write");

	// a taken write address closes the channel until the answer
	chk_aw_close: assert property (clk_en && awvalid && awready |=> !awready)
		else $error("write address ready not dropped");

	// the answer frees both write channels again
	chk_write_release: assert property (clk_en && bvalid && bready |=> !bvalid && awready && wready)
		else $error("write channels not released");

	// the answer frees the read address channel again
	chk_read_release: assert property (clk_en && rvalid && rready |=> !rvalid && arready)
		else $error("read channel not released");

	// no new write is taken while an answer waits
	chk_one_write: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");

	// a low clock enable freezes the bus and the converter side
	chk_freeze: assert property (!clk_en
		|=> $stable(bvalid) && $stable(rvalid) && $stable(awready) && $stable(analog_code))
		else $error("state moved with clock enable low");

	// a control read returns the stored bits
	chk_read_ctrl: assert property (clk_en && arvalid && arready && rd_dec[3] && !rd_dec[2]
		|=> rdata[CTRL_W-1:0] == $past(ctrl_reg[rd_dec[1:0]]))
		else $error("control read wrong");

	// a code read returns the stored field
	chk_read_code: assert property (clk_en && arvalid && arready && rd_dec[3] && rd_dec[2]
		|=> rdata[CODE_LSB+CODE_W-1:FRAC_LSB] == $past(data_reg[rd_dec[1:0]]))
		else $error("code read wrong");
endmodule // voltage_dac_control

// ===== dac_pkg.sv
// constants, register map and decode shared by the voltage converter control logic
// Contract
// - four independent channels, identical control and code layout
// - control resets to 0x100, read and write
// - power-down bit 8 tristates the output pin
// - bit 7 puts output amplifier in low power
// - bit 6 bypasses the output amplifier
// - bit 5 picks update timer or core clock
// - bit 4 low forces code register to zero
// - bit 3 high stops interpolator, normal mode
// - bit 2 picks interpolation divide 16 or 32
// - bits 1:0 select reference range
// - code in 27:16, extra bits 15:12, rest reserved
// - code register resets zero, read and write
// - control bits 15:9 read as zero
package dac_pkg;
	localparam int NCH = 4; // channel count
	localparam int CODE_W = 12; // converter code width
	localparam int FRAC_W = 4; // interpolation extra bits
	localparam int CTRL_W = 9; // stored control bits 8:0
	// register byte addresses, kept exactly as printed
	localparam logic [31:0] CTRL_ADDR [NCH] = '{32'hFFFF0580, 32'hFFFF0588, 32'hFFFF05B0, 32'hFFFF05D8};
	localparam logic [31:0] DATA_ADDR [NCH] = '{32'hFFFF0584, 32'h0FFF058C, 32'h0FFF05B4, 32'hFFFF05DC};
	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h100;
	localparam logic [CODE_W+FRAC_W-1:0] DATA_RESET = 16'h0000;
	// control field positions
	localparam int PD_BIT = 8;
	localparam int LP_BIT = 7;
	localparam int SKIP_BIT = 6;
	localparam int SRC_BIT = 5;
	localparam int CLR_BIT = 4;
	localparam int MODE_BIT = 3;
	localparam int RATE_BIT = 2;
	localparam int RANGE_LSB = 0;
	localparam int RANGE_W = 2;
	// code register field positions
	localparam int FRAC_LSB = 12;
	localparam int CODE_LSB = 16;
	// interpolation clock dividers
	localparam int DIV_FAST = 16;
	localparam int DIV_SLOW = 32;
	localparam int DIV_W = 5;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// address decode: {hit, is_code_reg, channel index}
	function automatic logic [3:0] reg_decode(input logic [31:0] addr);
		logic [3:0] res;
		res = 4'h0;
		for (int i = 0; i < NCH; i++) begin
			if (addr == CTRL_ADDR[i]) begin
				res = {2'b10, 2'(i)};
			end
			if (addr == DATA_ADDR[i]) begin
				res = {2'b11, 2'(i)};
			end
		end
		return res;
	endfunction
endpackage

// ===== dac_channel_core.sv
// one converter channel: update latch, interpolation dither and output controls
`timescale 1ns/1ps
module dac_channel_core import dac_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	// settings from the register block
	input wire logic [CTRL_W-1:0] ctrl,
	input wire logic [CODE_W+FRAC_W-1:0] code_in,
	input wire logic update_timer_evt,
	// converter side
	output logic [CODE_W-1:0] code_out,
	output logic pin_oe,
	output logic amp_low_power,
	output logic amp_skip,
	output logic [RANGE_W-1:0] range_out
);
	logic [CODE_W-1:0] held_code_reg; // code latched at update
	logic [FRAC_W-1:0] held_frac_reg; // extra bits latched at update
	logic [DIV_W-1:0] div_reg; // interpolation clock divider
	logic [FRAC_W-1:0] phase_reg; // dither phase
	logic update; // update event of the selected source
	logic tick; // one interpolation clock
	logic interp; // interpolation mode
	logic bump; // add one lsb this cycle

	assign interp = !ctrl[MODE_BIT];
	assign update = ctrl[SRC_BIT] ? update_timer_evt : 1'b1;
	assign tick = interp && (div_reg == (ctrl[RATE_BIT] ? DIV_W'(DIV_FAST - 1) : DIV_W'(DIV_SLOW - 1)));
	// saturate: full scale code never wraps to zero
	assign bump = interp && (phase_reg < held_frac_reg) && (held_code_reg != {CODE_W{1'b1}});

	// latch a new code only on an update event
	always_ff @(posedge core_clk) begin
		if (reset) begin
			held_code_reg <= '0;
			held_frac_reg <= '0;
		end else if (clk_en && update) begin
			held_code_reg <= code_in[CODE_W+FRAC_W-1:FRAC_W];
			held_frac_reg <= code_in[FRAC_W-1:0];
		end
	end

	// divider and phase are cleared and held at zero in normal mode
	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_reg <= '0;
			phase_reg <= '0;
		end else if (clk_en) begin
			if (!interp) begin
				div_reg <= '0;
				phase_reg <= '0;
			end else if (tick) begin
				div_reg <= '0;
				phase_reg <= phase_reg + 1'b1;
			end else begin
				div_reg <= div_reg + 1'b1;
			end
		end
	end

	// registered converter controls
	always_ff @(posedge core_clk) begin
		if (reset) begin
			code_out <= '0;
			pin_oe <= 1'b0;
			amp_low_power <= 1'b0;
			amp_skip <= 1'b0;
			range_out <= '0;
		end else if (clk_en) begin
			code_out <= held_code_reg + CODE_W'(bump);
			pin_oe <= !ctrl[PD_BIT];
			amp_low_power <= ctrl[LP_BIT];
			amp_skip <= ctrl[SKIP_BIT];
			range_out <= ctrl[RANGE_LSB +: RANGE_W];
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_pin_tristate: assert property (clk_en |=> pin_oe == !$past(ctrl[PD_BIT]))
		else $error("pin enable does not follow power-down");
	chk_amp_modes: assert property (clk_en |=> amp_low_power == $past(ctrl[LP_BIT]) && amp_skip == $past(ctrl[SKIP_BIT]))
		else $error("amplifier mode does not follow control");
	chk_range_sel: assert property (clk_en |=> range_out == $past(ctrl[1:0]))
		else $error("reference range does not follow control");
	chk_timer_hold: assert property (clk_en && ctrl[SRC_BIT] && !update_timer_evt |=> $stable(held_code_reg))
		else $error("code changed without timer event");
	chk_interp_stop: assert property (clk_en && ctrl[MODE_BIT] |=> div_reg == 0 && phase_reg == 0)
		else $error("interpolator runs in normal mode");
	chk_fast_rate: assert property (clk_en && interp && ctrl[RATE_BIT] && div_reg == 5'h0F |=> div_reg == 0)
		else $error("fast interpolation divide wrong");
	chk_slow_rate: assert property (clk_en && interp && !ctrl[RATE_BIT] && div_reg == 5'h0F
		|=> div_reg == 5'h10)
		else $error("slow interpolation divide wrong");
	chk_timer_take: assert property (clk_en && ctrl[SRC_BIT] && update_timer_evt
		|=> held_code_reg == $past(code_in[CODE_W+FRAC_W-1:FRAC_W]))
		else $error("timer event did not latch the code");
endmodule // dac_channel_core

// ===== voltage_dac_control_test.sv
// self-checking testbench for the four channel converter control block
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module voltage_dac_control_test import dac_pkg::*;;
	// bus and control drive, all set at time zero
	logic core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, update_timer_evt = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic [3:0] wstrb = 4'h0;
	// bready and rready stay high, so no two drives land in one step
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	logic [NCH*CODE_W-1:0] analog_code;
	logic [NCH-1:0] analog_output_pin_oe, buffer_low_power, buffer_skip;
	logic [NCH*RANGE_W-1:0] reference_range;
	// reference model: control, code register and expected converter code
	logic [31:0] mc [NCH];
	logic [31:0] md [NCH];
	logic [11:0] ec [NCH];
	logic [31:0] seed = 32'h00012A2D;
	int n_mismatch = 0, n_checks = 0, cyc = 0;

	always #20 core_clk = ~core_clk;

	voltage_dac_control u_voltage_dac_control (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
		.awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.update_timer_evt(update_timer_evt), .analog_code(analog_code),
		.analog_output_pin_oe(analog_output_pin_oe), .buffer_low_power(buffer_low_power),
		.buffer_skip(buffer_skip), .reference_range(reference_range));

	// xorshift source, fixed start
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// hang guard, far above the roughly 1300 cycles the run needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// one write: address and data offered together, each released when taken
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic pa, pw, pb;
		begin
			pa = 1'b1;
			pw = 1'b1;
			pb = 1'b1;
			awaddr <= a;
			wdata <= d;
			wstrb <= 4'hF;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			while (pb) begin
				@(posedge core_clk);
				if (!pa && !pw && bvalid === 1'b1) begin
					pb = 1'b0;
					rsp = bresp;
				end
				if (pa && awready === 1'b1) begin
					pa = 1'b0;
					awvalid <= 1'b0;
				end
				if (pw && wready === 1'b1) begin
					pw = 1'b0;
					wvalid <= 1'b0;
				end
			end
		end
	endtask

	// one read, answer taken at the edge that sees rvalid
	task rd_reg(input logic [31:0] a);
		logic pa, pr;
		begin
			pa = 1'b1;
			pr = 1'b1;
			araddr <= a;
			arvalid <= 1'b1;
			while (pr) begin
				@(posedge core_clk);
				if (pa && arready === 1'b1) begin
					pa = 1'b0;
					arvalid <= 1'b0;
				end else if (!pa && rvalid === 1'b1) begin
					pr = 1'b0;
					rd = rdata;
					rsp = rresp;
				end
			end
		end
	endtask

	// register write mirrored into the model
	task mwr(input int i, input bit dat, input logic [31:0] d);
		wr(dat ? DATA_ADDR[i] : CTRL_ADDR[i], d);
		`CHK(rsp, RESP_OKAY)
		if (dat) begin
			if (mc[i][4]) md[i] = d & 32'h0FFFF000;
		end else begin
			mc[i] = d & 32'h000001FF;
			if (!mc[i][4]) md[i] = 32'h0;
		end
	endtask

	// read back both registers and compare every converter side output
	task chk(input int i);
		if (!mc[i][5]) ec[i] = md[i][27:16];
		rd_reg(CTRL_ADDR[i]);
		`CHK(rd, mc[i])
		rd_reg(DATA_ADDR[i]);
		`CHK(rd, md[i])
		`CHK(analog_output_pin_oe[i], ~mc[i][8])
		`CHK(buffer_low_power[i], mc[i][7])
		`CHK(buffer_skip[i], mc[i][6])
		`CHK(reference_range[2*i +: 2], mc[i][1:0])
		`CHK(analog_code[12*i +: 12], ec[i])
	endtask

	// main sequence
	initial begin
		int i, k, c;
		for (i = 0; i < NCH; i++) begin
			mc[i] = 32'h00000100;
			md[i] = 32'h0;
			ec[i] = 12'h0;
		end
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		// reset values on every channel
		for (i = 0; i < NCH; i++) chk(i);
		// each range code, reserved bits set high, full scale code
		for (k = 0; k < NCH; k++) begin
			mwr(k, 0, 32'hFFFFFE18 | k);
			mwr(k, 1, 32'hFFFFFFFF);
			chk(k);
		end
		// random settings in core clock normal mode, clear bit random
		repeat (40) begin
			i = rnd() & 32'h00000003;
			mwr(i, 0, (rnd() & 32'hFFFFFFD7) | 32'h00000008);
			mwr(i, 1, rnd());
			chk(i);
		end
		// the word beside a seven digit address is not mapped
		wr(32'hFFFF058C, 32'h12345678);
		`CHK(rsp, RESP_SLVERR)
		rd_reg(32'hFFFF058C);
		`CHK(rsp, RESP_SLVERR)
		`CHK(rd, 32'h00000000)
		for (i = 0; i < NCH; i++) chk(i);
		// timer mode: new code waits for the timer event
		mwr(1, 0, 32'h00000038);
		mwr(1, 1, 32'h0ABC0000);
		repeat (5) @(posedge core_clk);
		chk(1);
		update_timer_evt <= 1'b1;
		@(posedge core_clk);
		update_timer_evt <= 1'b0;
		ec[1] = 12'hABC;
		repeat (3) @(posedge core_clk);
		chk(1);
		// a timer event while the clock enable is low is lost
		mwr(1, 1, 32'h05550000);
		clk_en <= 1'b0;
		update_timer_evt <= 1'b1;
		@(posedge core_clk);
		clk_en <= 1'b1;
		update_timer_evt <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(1);
		update_timer_evt <= 1'b1;
		@(posedge core_clk);
		update_timer_evt <= 1'b0;
		ec[1] = 12'h555;
		repeat (3) @(posedge core_clk);
		chk(1);
		// interpolation: half of the phases show code plus one, at both rates
		for (k = 0; k < 2; k++) begin
			mwr(2, 0, k ? 32'h00000010 : 32'h00000014);
			// code goes in after the clear bit is up, else it is dropped
			mwr(2, 1, 32'h01008000);
			repeat (4) @(posedge core_clk);
			c = 0;
			repeat (k ? 512 : 256) begin
				@(posedge core_clk);
				if (analog_code[35:24] === 12'h101) c++;
			end
			`CHK(c, k ? 256 : 128)
		end
		give_verdict();
	end
endmodule // voltage_dac_control_test
